/* rtl/tpwm_top.sv */
// two-channel timer pwm block with ahb-lite register slave
// Functional notes
// RULE1: toggle-on-wrap inverts the channel pin at each counter wrap
// RULE2: pulse width runs from counter wrap to compare match
// RULE3: period is wrap limit plus one prescaled ticks
// RULE4: 8-bit setup gives 256 width steps of one tick
// RULE5: unbuffered compare writes act at once; passed values miss a compare
// RULE6: software writes shorter widths at compare irq, longer at wrap irq
// RULE7: software must not use toggle-on-compare for pwm
// RULE8: buffer-link pairs channels 0 and 1 onto pin 0, channel 0 first
// RULE9: in linked mode the last written channel takes over at next wrap
// RULE10: linked mode uses channel 0 control; channel 1 pin released
// RULE11: software writes only the inactive channel in linked mode
// RULE12: software follows halt, limit, compare, mode, toggle, action, run order
// RULE13: compare drives pin to complement of pulse level (10 clear, 11 set)
// RULE14: buffer-link overrides the unbuffered mode bit
// RULE15: without toggle-on-wrap no wrap toggles; output stays at 0% duty
// RULE16: full-duty force with toggle-on-wrap holds 100% duty
// RULE17: wrap sets wrap flag; irq only with wrap irq enable
// RULE18: compare sets channel flag; irq only with channel irq enable
// RULE19: wait state keeps timer running, blocks register access, irq wakes
// RULE20: software halts the timer before wait if it is not needed
// RULE21: break freezes the counter while it lasts
// RULE22: flag clear during break only with break flag clear enable set
// RULE23: armed two-step clear holds through break, completes afterwards
// RULE24: counter restarts from zero on the tick after the limit
// RULE25: divide select gives /1 to /64; code 111 gives no ticks
// RULE26: compare match is full 16-bit equality once per tick
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tpwm_params.svh"
module tpwm_top
    import tpwm_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        BREAK_ACTIVE,
    input  wire logic        WAIT_MODE,
    output logic             CHANNEL0_PIN,
    output logic             CHANNEL0_PIN_OE_N,
    output logic             CHANNEL1_PIN,
    output logic             CHANNEL1_PIN_OE_N,
    output logic             TIMER_IRQ
);

    tpwm_tctl_t         tctl_r;
    tpwm_chctl_t        ctl_r [2];
    logic [CNT_W-1:0]   cmp_r [2];
    logic [CNT_W-1:0]   limit_r;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic [5:0]         pre_r;
    logic               break_flag_clear_enable_r;
    logic               wflag_arm_r;
    logic [1:0]         cflag_arm_r;
    logic [1:0]         pin_r;
    logic [1:0]         pin_oe_n_r;
    logic               act_r;
    logic               last_wr_r;
    logic               irq_r;
    logic [31:0]        rdata_r;
    tpwm_aph_t          aph_r;
    logic               aph_ok;
    logic               wr_en;
    logic               flag_ok;
    logic               run;
    logic               tick;
    logic               wrap_ev;
    logic               link;
    logic [1:0]         pin_en;
    logic [1:0]         cmp_ev;
    logic [CNT_W-1:0]   eff_cmp [2];

    // tick when the low prescaler bits for the selected ratio are all ones
    function automatic logic tick_f(input logic [5:0] pre, input logic [2:0] div);
        logic [5:0] mask;
        mask = 6'h00;
        for (int k = 0; k < 6; k++) begin
            if (k < int'(div)) begin
                mask[k] = 1'b1;
            end
        end
        return (div != `TPWM_DIV_NONE) && ((pre & mask) == mask);
    endfunction : tick_f

    // two-step flag: set wins, clear needs arming and a zero written
    function automatic logic flag_f(input logic flag, input logic set, input logic arm,
                                    input logic clr_wr, input logic ok);
        return set | (flag & ~(arm & clr_wr & ok));
    endfunction : flag_f

    function automatic logic [31:0] zx_f(input logic [CNT_W-1:0] v);
        return 32'(v);
    endfunction : zx_f

    // bus side
    assign aph_ok  = HSEL && HTRANS[1] && HREADY && !WAIT_MODE; // RULE19
    assign wr_en   = aph_r.valid && aph_r.write;
    assign flag_ok = !BREAK_ACTIVE || break_flag_clear_enable_r; // RULE22

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aph_r <= '0;
        end else if (HREADY) begin
            aph_r <= '{valid: aph_ok, write: HWRITE, addr: HADDR[7:0]};
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r   <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            if (aph_ok && !HWRITE) begin
                case (HADDR[7:0])
                    `TPWM_OFS_TCTL:   rdata_r <= {24'h00_0000, tctl_r.flag, tctl_r.irq_en,
                                                  tctl_r.halt, 2'b00, tctl_r.div};
                    `TPWM_OFS_COUNT:  rdata_r <= zx_f(cnt_r);
                    `TPWM_OFS_LIMIT:  rdata_r <= zx_f(limit_r);
                    `TPWM_OFS_CH0CTL: rdata_r <= {24'h00_0000, ctl_r[0]};
                    `TPWM_OFS_CH0CMP: rdata_r <= zx_f(cmp_r[0]);
                    `TPWM_OFS_CH1CTL: rdata_r <= {24'h00_0000, ctl_r[1]};
                    `TPWM_OFS_CH1CMP: rdata_r <= zx_f(cmp_r[1]);
                    `TPWM_OFS_BRKCTL: rdata_r <= {24'h00_0000, break_flag_clear_enable_r, 7'h00};
                    default:          rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign HRDATA = rdata_r;

    // arming of the two-step clears on a read that sees the flag set
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wflag_arm_r <= 1'b0;
            cflag_arm_r <= 2'b00;
        end else begin
            if (aph_ok && !HWRITE && flag_ok && HADDR[7:0] == `TPWM_OFS_TCTL && tctl_r.flag) begin
                wflag_arm_r <= 1'b1; // RULE23
            end else if (!tctl_r.flag) begin
                wflag_arm_r <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (aph_ok && !HWRITE && flag_ok && ctl_r[i].flag &&
                    HADDR[7:0] == (i == 0 ? `TPWM_OFS_CH0CTL : `TPWM_OFS_CH1CTL)) begin
                    cflag_arm_r[i] <= 1'b1; // RULE23
                end else if (!ctl_r[i].flag) begin
                    cflag_arm_r[i] <= 1'b0;
                end
            end
        end
    end

    // timer control, limit and break control
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tctl_r      <= '0;
            tctl_r.halt <= `TPWM_RST_HALT;
            limit_r     <= `TPWM_RST_LIMIT;
            break_flag_clear_enable_r      <= 1'b0;
        end else begin
            tctl_r.clr  <= 1'b0;
            tctl_r.flag <= flag_f(tctl_r.flag, wrap_ev, wflag_arm_r,
                                  wr_en && aph_r.addr == `TPWM_OFS_TCTL &&
                                  !HWDATA[`TPWM_FLAG_BIT], flag_ok); // RULE17 RULE22
            if (wr_en && aph_r.addr == `TPWM_OFS_TCTL) begin
                tctl_r.irq_en <= HWDATA[6];
                tctl_r.halt   <= HWDATA[5];
                tctl_r.clr    <= HWDATA[4];
                tctl_r.div    <= HWDATA[2:0];
            end
            if (wr_en && aph_r.addr == `TPWM_OFS_LIMIT) begin
                limit_r <= HWDATA[CNT_W-1:0];
            end
            if (wr_en && aph_r.addr == `TPWM_OFS_BRKCTL) begin
                break_flag_clear_enable_r <= HWDATA[`TPWM_BREAK_FLAG_CLEAR_ENABLE_BIT];
            end
        end
    end

    // prescaler and counter
    assign run     = !tctl_r.halt && !BREAK_ACTIVE; // RULE21
    assign tick    = tick_f(pre_r, tctl_r.div); // RULE25
    assign wrap_ev = run && tick && (cnt_r == limit_r); // RULE3
    assign cnt_nxt = wrap_ev ? '0 : cnt_r + CNT_W'(1); // RULE24

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_r <= 6'h00;
            cnt_r <= '0;
        end else if (tctl_r.clr) begin
            pre_r <= 6'h00;
            cnt_r <= '0;
        end else if (run) begin
            pre_r <= pre_r + 6'h01;
            if (wrap_ev) begin
                cnt_r <= '0; // RULE24
            end else if (tick) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    // channel control and compare values
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_r[0]  <= '0;
            ctl_r[1]  <= '0;
            cmp_r[0]  <= '0;
            cmp_r[1]  <= '0;
            last_wr_r <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ctl_r[i].flag <= flag_f(ctl_r[i].flag, cmp_ev[i], cflag_arm_r[i],
                                        wr_en && !HWDATA[`TPWM_FLAG_BIT] &&
                                        aph_r.addr == (i == 0 ? `TPWM_OFS_CH0CTL
                                                              : `TPWM_OFS_CH1CTL),
                                        flag_ok); // RULE18 RULE22 RULE23
                if (wr_en && aph_r.addr == (i == 0 ? `TPWM_OFS_CH0CTL : `TPWM_OFS_CH1CTL)) begin
                    ctl_r[i].irq_en <= HWDATA[6];
                    ctl_r[i].mode_b <= (i == 0) ? HWDATA[5] : 1'b0;
                    ctl_r[i].mode_a <= HWDATA[4];
                    ctl_r[i].els    <= HWDATA[3:2];
                    ctl_r[i].tov    <= HWDATA[1];
                    ctl_r[i].max    <= HWDATA[0];
                end
                if (wr_en && aph_r.addr == (i == 0 ? `TPWM_OFS_CH0CMP : `TPWM_OFS_CH1CMP)) begin
                    cmp_r[i]  <= HWDATA[CNT_W-1:0]; // RULE5
                    last_wr_r <= (i == 1); // RULE9
                end
            end
        end
    end

    // linked pairing: channel 0 control governs, active half swaps at wrap
    assign link       = ctl_r[0].mode_b; // RULE8 RULE14
    assign pin_en[0]  = (link || ctl_r[0].mode_a) && ctl_r[0].els != 2'b00;
    assign pin_en[1]  = !link && ctl_r[1].mode_a && ctl_r[1].els != 2'b00; // RULE10
    assign eff_cmp[0] = (link && (wrap_ev ? last_wr_r : act_r)) ? cmp_r[1] : cmp_r[0];
    assign eff_cmp[1] = cmp_r[1];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // match on the value the counter steps to, so width equals compare value
            cmp_ev[i] = pin_en[i] && run && tick && (cnt_nxt == eff_cmp[i]); // RULE26 RULE2
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            act_r <= 1'b0;
        end else if (!link) begin
            act_r <= 1'b0;
        end else if (wrap_ev) begin
            act_r <= last_wr_r; // RULE9
        end
    end

    // pin waveform
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_r      <= 2'b00;
            pin_oe_n_r <= 2'b11;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pin_oe_n_r[i] <= !pin_en[i]; // RULE10
                if (pin_en[i] && ctl_r[i].tov && ctl_r[i].max) begin
                    pin_r[i] <= !ctl_r[i].els[0]; // RULE16
                end else if (cmp_ev[i]) begin
                    case (ctl_r[i].els)
                        2'b01:   pin_r[i] <= !pin_r[i];
                        2'b10:   pin_r[i] <= 1'b0; // RULE13
                        2'b11:   pin_r[i] <= 1'b1; // RULE13
                        default: pin_r[i] <= pin_r[i];
                    endcase
                end else if (wrap_ev && pin_en[i] && ctl_r[i].tov) begin
                    pin_r[i] <= !pin_r[i]; // RULE1 RULE15 RULE4
                end
            end
        end
    end

    // interrupt request, also serves as wake-up from wait
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (tctl_r.flag && tctl_r.irq_en) ||
                     (ctl_r[0].flag && ctl_r[0].irq_en) ||
                     (ctl_r[1].flag && ctl_r[1].irq_en && !link); // RULE17 RULE18 RULE19
        end
    end

    assign CHANNEL0_PIN      = pin_r[0];
    assign CHANNEL1_PIN      = pin_r[1];
    assign CHANNEL0_PIN_OE_N = pin_oe_n_r[0];
    assign CHANNEL1_PIN_OE_N = pin_oe_n_r[1];
    assign TIMER_IRQ         = irq_r;

    a_wrap_flag_set: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE17
        wrap_ev |=> tctl_r.flag)
        else $error("wrap flag not set after wrap");
    a_counter_restart: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE24
        wrap_ev && !tctl_r.clr |=> cnt_r == '0)
        else $error("counter did not restart at zero");
    a_counter_step: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE3
        run && tick && !wrap_ev && !tctl_r.clr |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("counter did not advance on tick");
    a_break_freeze: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE21
        BREAK_ACTIVE && !tctl_r.clr |=> $stable(cnt_r))
        else $error("counter moved during break");
    a_div_blocked: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE25
        tctl_r.div == `TPWM_DIV_NONE |-> !tick)
        else $error("tick with unavailable divide code");
    a_full_duty: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE16
        pin_en[0] && ctl_r[0].tov && ctl_r[0].max |=> CHANNEL0_PIN == !$past(ctl_r[0].els[0]))
        else $error("full duty level not held");
    a_compare_clear: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE13
        cmp_ev[0] && ctl_r[0].els == 2'b10 && !ctl_r[0].max |=> !CHANNEL0_PIN)
        else $error("compare did not clear pin");
    a_no_wrap_toggle: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE15
        wrap_ev && !ctl_r[0].tov && !cmp_ev[0] |=> $stable(CHANNEL0_PIN))
        else $error("pin toggled at wrap without toggle-on-wrap");
    a_link_swap: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE9
        link && wrap_ev |=> act_r == $past(last_wr_r))
        else $error("active channel not taken at wrap");
    a_ch1_released: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE10
        link |=> CHANNEL1_PIN_OE_N)
        else $error("channel 1 pin driven while linked");
    a_break_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE22
        BREAK_ACTIVE && !break_flag_clear_enable_r && ctl_r[0].flag |=> ctl_r[0].flag)
        else $error("flag cleared during protected break");
    a_wait_block: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // RULE19
        HSEL && HTRANS[1] && HREADY && WAIT_MODE |=> !aph_r.valid && HRDATA == 32'h0000_0000)
        else $error("register access during wait");

endmodule : tpwm_top

/* rtl/tpwm_params.svh */
// register offsets, reset values and field positions of the timer pwm block
`ifndef TPWM_PARAMS_SVH
`define TPWM_PARAMS_SVH
`define TPWM_OFS_TCTL    8'h00
`define TPWM_OFS_COUNT   8'h04
`define TPWM_OFS_LIMIT   8'h08
`define TPWM_OFS_CH0CTL  8'h0c
`define TPWM_OFS_CH0CMP  8'h10
`define TPWM_OFS_CH1CTL  8'h14
`define TPWM_OFS_CH1CMP  8'h18
`define TPWM_OFS_BRKCTL  8'h1c
`define TPWM_RST_LIMIT   16'hffff
`define TPWM_RST_HALT    1'b1
`define TPWM_DIV_NONE    3'h7
`define TPWM_FLAG_BIT    7
`define TPWM_BREAK_FLAG_CLEAR_ENABLE_BIT    7
`endif

/* rtl/tpwm_pkg.sv */
// types shared by the timer pwm block
package tpwm_pkg;
    typedef struct packed {
        logic       flag;
        logic       irq_en;
        logic       mode_b;
        logic       mode_a;
        logic [1:0] els;
        logic       tov;
        logic       max;
    } tpwm_chctl_t;

    typedef struct packed {
        logic       flag;
        logic       irq_en;
        logic       halt;
        logic       clr;
        logic       rsvd;
        logic [2:0] div;
    } tpwm_tctl_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } tpwm_aph_t;
endpackage : tpwm_pkg

/* verification/tpwm_load.sv */
// external load on a pwm pin: resolves the wire and counts high cycles
`timescale 1ns/1ps
module tpwm_load (
    input  wire logic        clk,
    input  wire logic        pin,
    input  wire logic        oe_n,
    input  wire logic        clr,
    output logic             level,
    output logic [31:0]      high_cnt
);
    // pull-down holds the wire low whenever the block releases it
    assign level = oe_n ? 1'b0 : pin;

    always_ff @(posedge clk) begin
        if (clr) begin
            high_cnt <= 32'h0;
        end else begin
            high_cnt <= high_cnt + {31'h0, level};
        end
    end
endmodule : tpwm_load

/* verification/timer_pwm_channels_test.sv */
// self-checking bench for the timer pwm block
`timescale 1ns/1ps
`include "tpwm_params.svh"
module timer_pwm_channels_test;
    logic        core_clk, arst_n, hsel, hwrite, brk, wt, clr;
    logic        hreadyout, hresp, pin0, oe0_n, pin1, oe1_n, irq, lvl;
    logic [31:0] haddr, hwdata, hrdata, cnt, r, r2;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          mismatches, samples_checked, seed;

    always #2.5 core_clk = ~core_clk;

    tpwm_top tpwm_top_i (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .BREAK_ACTIVE(brk), .WAIT_MODE(wt), .CHANNEL0_PIN(pin0),
        .CHANNEL0_PIN_OE_N(oe0_n), .CHANNEL1_PIN(pin1),
        .CHANNEL1_PIN_OE_N(oe1_n), .TIMER_IRQ(irq)
    );

    tpwm_load tpwm_load_i (
        .clk(core_clk), .pin(pin0), .oe_n(oe0_n), .clr(clr), .level(lvl), .high_cnt(cnt)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // waits for hready sampled high at a rising edge, bounded
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                mismatches++;
                wrap_up();
            end
            @(posedge core_clk);
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        wait_ready();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    // halt and clear, limit, compare, mode, toggle, action, then run
    task automatic setup(input int lim, input int c, input logic [7:0] ctl, input int dv);
        wr(`TPWM_OFS_TCTL, 32'h30);
        wr(`TPWM_OFS_LIMIT, {16'h0, 16'(lim)});
        wr(`TPWM_OFS_CH0CMP, {16'h0, 16'(c)});
        wr(`TPWM_OFS_CH0CTL, {24'h0, ctl & 8'h30});
        wr(`TPWM_OFS_CH0CTL, {24'h0, ctl & 8'h33});
        wr(`TPWM_OFS_CH0CTL, {24'h0, ctl});
        wr(`TPWM_OFS_TCTL, {29'h0, 3'(dv)});
    endtask : setup

    // high cycles seen by the load over n clock cycles
    task automatic measure(input int n, output logic [31:0] hi);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
        hi = cnt;
        @(posedge core_clk);
    endtask : measure

    function automatic int per(input int lim, input int dv);
        return (lim + 1) << dv;
    endfunction : per

    // settles three periods, then expects w high ticks in each of four periods
    task automatic pwm_case(input int lim, input int c, input logic [7:0] ctl,
                            input int dv, input int w);
        logic [31:0] h;
        setup(lim, c, ctl, dv);
        repeat (3 * per(lim, dv)) @(posedge core_clk);
        measure(4 * per(lim, dv), h);
        chk(h, 32'(4 * (w << dv)));
    endtask : pwm_case

    initial begin
        #500000;
        mismatches++;
        wrap_up();
    end

    initial begin
        int lim;
        int c;
        int dv;
        core_clk = 1'b0;
        arst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        brk = 1'b0;
        wt = 1'b0;
        clr = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        seed = 32'hac46ad36;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(`TPWM_OFS_TCTL, r);
        chk(r, 32'h20);
        rd(`TPWM_OFS_LIMIT, r);
        chk(r, 32'hffff);
        rd(8'h40, r);
        chk(r, 32'h0);
        pwm_case(255, 128, 8'h1a, 0, 128);
        for (int i = 0; i < 6; i++) begin
            lim = 3 + int'($unsigned($random(seed)) % 13);
            c   = int'($unsigned($random(seed)) % lim);
            dv  = int'($unsigned($random(seed)) % 3);
            if (i[0]) begin
                pwm_case(lim, c, 8'h1e, dv, lim + 1 - c);
            end else begin
                pwm_case(lim, c, 8'h1a, dv, c);
            end
        end
        pwm_case(9, 4, 8'h18, 0, 0);
        pwm_case(9, 4, 8'h1b, 0, 10);
        rd(`TPWM_OFS_CH0CTL, r);
        chk({31'h0, r[7]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`TPWM_OFS_TCTL, 32'h40);
        repeat (12) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`TPWM_OFS_TCTL, 32'h0);
        wr(`TPWM_OFS_CH0CTL, 32'h5b);
        repeat (12) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`TPWM_OFS_CH0CTL, 32'h1b);
        brk <= 1'b1;
        @(posedge core_clk);
        rd(`TPWM_OFS_COUNT, r);
        repeat (20) @(posedge core_clk);
        rd(`TPWM_OFS_COUNT, r2);
        chk(r2, r);
        brk <= 1'b0;
        @(posedge core_clk);
        wr(`TPWM_OFS_TCTL, 32'h20);
        rd(`TPWM_OFS_TCTL, r);
        chk({31'h0, r[7]}, 32'h1);
        brk <= 1'b1;
        @(posedge core_clk);
        wr(`TPWM_OFS_TCTL, 32'h20);
        rd(`TPWM_OFS_TCTL, r);
        chk({31'h0, r[7]}, 32'h1);
        brk <= 1'b0;
        @(posedge core_clk);
        wr(`TPWM_OFS_TCTL, 32'h20);
        rd(`TPWM_OFS_TCTL, r);
        chk({31'h0, r[7]}, 32'h0);
        wr(`TPWM_OFS_TCTL, 32'h0);
        repeat (12) @(posedge core_clk);
        wr(`TPWM_OFS_TCTL, 32'h20);
        wr(`TPWM_OFS_BRKCTL, 32'h80);
        brk <= 1'b1;
        @(posedge core_clk);
        rd(`TPWM_OFS_TCTL, r);
        wr(`TPWM_OFS_TCTL, 32'h20);
        brk <= 1'b0;
        @(posedge core_clk);
        rd(`TPWM_OFS_TCTL, r);
        chk({31'h0, r[7]}, 32'h0);
        wt <= 1'b1;
        @(posedge core_clk);
        rd(`TPWM_OFS_LIMIT, r);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wt <= 1'b0;
        @(posedge core_clk);
        rd(`TPWM_OFS_LIMIT, r);
        chk(r, 32'h9);
        pwm_case(7, 2, 8'h3a, 0, 2);
        wr(`TPWM_OFS_CH1CTL, 32'h18);
        @(posedge core_clk);
        chk({31'h0, oe1_n}, 32'h1);
        wr(`TPWM_OFS_CH1CMP, 32'h5);
        repeat (16) @(posedge core_clk);
        measure(32, r);
        chk(r, 32'd20);
        wr(`TPWM_OFS_CH0CMP, 32'h1);
        repeat (16) @(posedge core_clk);
        measure(32, r);
        chk(r, 32'd4);
        setup(7, 2, 8'h1a, 7);
        repeat (10) @(posedge core_clk);
        rd(`TPWM_OFS_COUNT, r);
        chk(r, 32'h0);
        chk({31'h0, oe1_n}, 32'h0);
        chk({31'h0, pin1}, 32'h0);
        wrap_up();
    end
endmodule : timer_pwm_channels_test
